// [common/scbsa_pkg.sv]
// Constants and types for the serial control bus slave and proxy master
// ======================================================================
// What this block does
// R1: Slave answers one of eight selectable addresses.
// R2: Strap levels 0..7 give addresses 2C,2E,30,32,34,36,38,3C.
// R3: SDA falling while SCL high is start; mid-transaction it is repeated start.
// R4: SDA rising while SCL high is stop and ends the transaction.
// R5: Matching address is acknowledged by pulling SDA low.
// R6: Non-matching address leaves SDA released, giving not-acknowledge.
// R7: Each received write byte is acknowledged by driving SDA low.
// R8: Master acknowledges read bytes, not-acknowledges the last, then stops.
// R9: Transactions open with start or repeated start, close with stop.
// R10: SCL input, SDA two-way; lines only driven low or released.
// R11: Proxy master waits while SCL is held low by a slave.
// R12: Proxy master sending one but seeing zero loses arbitration, releases SDA.
// R13: After lost arbitration, wait for idle bus, restart whole transaction.
// R14: Camera-side master must not reach host-side slaves over the channel.
// R15: Local and remote register accesses are arbitrated without corruption.
// R16: Only one channel direction active; control handed over explicitly.
// R17: Two read/write mailbox registers at offsets 18h and 19h.
// R18: No restart or stop while another master sends a bit.
// R19: Older partners: one controller only, or local access only.
// R20: Same-register simultaneous local and remote accesses still work.
// R21: Offset 0 holds address in bits 7..1; bit 0 selects stored address.
// R22: First byte after start is address plus direction bit, one is read.
package scbsa_pkg;

  // ======================================================================
  // Clock and timing
  localparam int SYS_CLK_MHZ = 100;
  localparam int PM_HALF_NS  = 500;
  localparam int PM_BUF_NS   = 1300;
  localparam int PM_HALF_CYC = (PM_HALF_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam int PM_BUF_CYC  = (PM_BUF_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam logic [7:0] PM_HALF_CNT = PM_HALF_CYC[7:0];
  localparam logic [7:0] PM_BUF_CNT  = PM_BUF_CYC[7:0];

  // ======================================================================
  // Register map
  localparam logic [7:0] REG_ADDR_OFS  = 8'h00;
  localparam logic [7:0] MAILBOX1_OFS  = 8'h18;
  localparam logic [7:0] MAILBOX2_OFS  = 8'h19;
  localparam logic [7:0] MAILBOX_RST   = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam int         OVR_SEL_BIT   = 0;

  // ======================================================================
  // Strap decode and settle
  localparam logic [6:0] STRAP_ADDR [8] = '{7'h2C, 7'h2E, 7'h30, 7'h32,
                                            7'h34, 7'h36, 7'h38, 7'h3C};
  localparam logic [1:0] STRAP_SETTLE   = 2'h3;

  // ======================================================================
  // Bit counts
  localparam logic [3:0] BYTE_BITS  = 4'h8;
  localparam logic [4:0] PM_LAST    = 5'h11;
  localparam logic [4:0] PM_ACK1    = 5'h08;
  localparam logic [4:0] PM_ACK2    = 5'h11;

  // ======================================================================
  // State machines
  typedef enum logic [4:0] {
    SL_IDLE  = 5'b00001,
    SL_ADDR  = 5'b00010,
    SL_ACK   = 5'b00100,
    SL_WRITE = 5'b01000,
    SL_READ  = 5'b10000
  } scbsa_sl_t;

  typedef enum logic [6:0] {
    PM_IDLE  = 7'b0000001,
    PM_WAIT  = 7'b0000010,
    PM_START = 7'b0000100,
    PM_LOW   = 7'b0001000,
    PM_HIGH  = 7'b0010000,
    PM_STOPL = 7'b0100000,
    PM_STOPH = 7'b1000000
  } scbsa_pm_t;

endpackage

// [core/scbsa_core.sv]
// Serial control bus slave, register file, arbiter and proxy master
`timescale 1ns/1ns
`default_nettype none
module scbsa_core
  import scbsa_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  input  wire logic [2:0] address_strap_pin,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       rm_req,
  input  wire logic       rm_we,
  input  wire logic [7:0] rm_addr,
  input  wire logic [7:0] rm_wdata,
  output logic            rm_ack,
  output logic [7:0]      rm_rdata,
  input  wire logic       pm_req,
  input  wire logic [6:0] pm_addr,
  input  wire logic [7:0] pm_data,
  output logic            pm_busy,
  output logic            pm_done,
  output logic            pm_nack,
  output logic            pm_arb_lost,
  input  wire logic       back_channel_link_scl_in,
  output logic            back_channel_link_scl_out,
  output logic            back_channel_link_scl_oe,
  input  wire logic       back_channel_link_sda_in,
  output logic            back_channel_link_sda_out,
  output logic            back_channel_link_sda_oe
);

  // ======================================================================
  // Declarations
  logic [1:0] scl_sync_reg;
  logic [1:0] sda_sync_reg;
  logic       scl_prev_reg;
  logic       sda_prev_reg;
  logic [1:0] bscl_sync_reg;
  logic [1:0] bsda_sync_reg;
  logic [2:0] strap_sync1_reg;
  logic [2:0] strap_sync2_reg;
  logic [1:0] strap_cnt_reg;
  logic [6:0] stored_slave_address_reg;
  logic       address_override_select_reg;
  logic [7:0] mailbox_first_reg;
  logic [7:0] mailbox_second_reg;
  logic [6:0] own_addr;
  logic       scl_s;
  logic       sda_s;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_det;
  logic       stop_det;
  scbsa_sl_t  sl_state_reg;
  logic [3:0] sl_bits_reg;
  logic [7:0] sl_shift_reg;
  logic [7:0] sl_tx_reg;
  logic [7:0] sl_ptr_reg;
  logic       sl_rw_reg;
  logic       sl_first_reg;
  logic       sl_sda_low_reg;
  logic       sl_nack_reg;
  logic       sl_wr_reg;
  logic [7:0] sl_wr_addr_reg;
  logic [7:0] sl_wr_data_reg;
  logic       rm_take;
  logic       rm_ack_reg;
  logic [7:0] rm_rdata_reg;
  scbsa_pm_t  pm_state_reg;
  logic [7:0] pm_cnt_reg;
  logic [4:0] pm_bit_reg;
  logic [17:0] pm_shift_reg;
  logic [17:0] pm_frame_reg;
  logic       pm_scl_oe_reg;
  logic       pm_sda_oe_reg;
  logic       pm_done_reg;
  logic       pm_nack_reg;
  logic       pm_lost_reg;
  logic       pm_ack_slot;
  logic [7:0] sl_rd_byte;
  logic       wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;

  // ======================================================================
  // Register read decode
  function automatic logic [7:0] reg_read(input logic [7:0] ofs,
                                          input logic [6:0] addr,
                                          input logic       ovr,
                                          input logic [7:0] mb1,
                                          input logic [7:0] mb2);
    logic [7:0] val;
    val = UNMAPPED_READ;
    case (ofs)
      // R21: address and select
      REG_ADDR_OFS: val = {addr, ovr};
      // R17: mailbox readback
      MAILBOX1_OFS: val = mb1;
      MAILBOX2_OFS: val = mb2;
      default:      val = UNMAPPED_READ;
    endcase
    return val;
  endfunction

  // ======================================================================
  // Input synchronisers
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      scl_sync_reg    <= 2'h3;
      sda_sync_reg    <= 2'h3;
      scl_prev_reg    <= 1'b1;
      sda_prev_reg    <= 1'b1;
      bscl_sync_reg   <= 2'h3;
      bsda_sync_reg   <= 2'h3;
      strap_sync1_reg <= 3'h0;
      strap_sync2_reg <= 3'h0;
    end else begin
      scl_sync_reg    <= {scl_sync_reg[0], scl_in};
      sda_sync_reg    <= {sda_sync_reg[0], sda_in};
      scl_prev_reg    <= scl_sync_reg[1];
      sda_prev_reg    <= sda_sync_reg[1];
      bscl_sync_reg   <= {bscl_sync_reg[0], back_channel_link_scl_in};
      bsda_sync_reg   <= {bsda_sync_reg[0], back_channel_link_sda_in};
      strap_sync1_reg <= address_strap_pin;
      strap_sync2_reg <= strap_sync1_reg;
    end
  end

  assign scl_s    = scl_sync_reg[1];
  assign sda_s    = sda_sync_reg[1];
  assign scl_rise = scl_s & ~scl_prev_reg;
  assign scl_fall = ~scl_s & scl_prev_reg;
  // R3: start detect
  assign start_det = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
  // R4: stop detect
  assign stop_det  = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;

  // R1: selected own address
  assign own_addr = address_override_select_reg ? stored_slave_address_reg
                                                : STRAP_ADDR[strap_sync2_reg];
  assign sl_rd_byte = reg_read(sl_ptr_reg, stored_slave_address_reg,
                               address_override_select_reg,
                               mailbox_first_reg, mailbox_second_reg);

  // ======================================================================
  // Register file with local/remote arbitration
  assign rm_take = rm_req & ~sl_wr_reg & ~rm_ack_reg;
  // R15: local write wins cycle
  assign wr_en   = sl_wr_reg | (rm_take & rm_we);
  // R20: remote write serialised after local
  assign wr_addr = sl_wr_reg ? sl_wr_addr_reg : rm_addr;
  assign wr_data = sl_wr_reg ? sl_wr_data_reg : rm_wdata;

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      strap_cnt_reg               <= 2'h0;
      stored_slave_address_reg    <= STRAP_ADDR[0];
      address_override_select_reg <= 1'b0;
      mailbox_first_reg           <= MAILBOX_RST;
      mailbox_second_reg          <= MAILBOX_RST;
    end else if (strap_cnt_reg != STRAP_SETTLE) begin
      // R2: strap decode to address
      strap_cnt_reg               <= strap_cnt_reg + 2'h1;
      stored_slave_address_reg    <= STRAP_ADDR[strap_sync2_reg];
      address_override_select_reg <= 1'b0;
    end else if (wr_en) begin
      case (wr_addr)
        REG_ADDR_OFS: begin
          stored_slave_address_reg    <= wr_data[7:1];
          address_override_select_reg <= wr_data[OVR_SEL_BIT];
        end
        MAILBOX1_OFS: mailbox_first_reg  <= wr_data;
        MAILBOX2_OFS: mailbox_second_reg <= wr_data;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      rm_ack_reg   <= 1'b0;
      rm_rdata_reg <= 8'h00;
    end else begin
      rm_ack_reg <= rm_take;
      if (rm_take) begin
        rm_rdata_reg <= reg_read(rm_addr, stored_slave_address_reg,
                                 address_override_select_reg,
                                 mailbox_first_reg, mailbox_second_reg);
      end
    end
  end

  assign rm_ack   = rm_ack_reg;
  assign rm_rdata = rm_rdata_reg;

  // ======================================================================
  // Slave protocol engine
  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      sl_state_reg   <= SL_IDLE;
      sl_bits_reg    <= 4'h0;
      sl_shift_reg   <= 8'h00;
      sl_tx_reg      <= 8'h00;
      sl_ptr_reg     <= 8'h00;
      sl_rw_reg      <= 1'b0;
      sl_first_reg   <= 1'b0;
      sl_sda_low_reg <= 1'b0;
      sl_nack_reg    <= 1'b0;
      sl_wr_reg      <= 1'b0;
      sl_wr_addr_reg <= 8'h00;
      sl_wr_data_reg <= 8'h00;
    end else begin
      sl_wr_reg <= 1'b0;
      if (start_det) begin
        // R9: every transfer opens here
        sl_state_reg   <= SL_ADDR;
        sl_bits_reg    <= 4'h0;
        sl_sda_low_reg <= 1'b0;
      end else if (stop_det) begin
        sl_state_reg   <= SL_IDLE;
        sl_sda_low_reg <= 1'b0;
      end else begin
        case (sl_state_reg)
          SL_ADDR, SL_WRITE: begin
            if (scl_rise && sl_bits_reg != BYTE_BITS) begin
              sl_shift_reg <= {sl_shift_reg[6:0], sda_s};
              sl_bits_reg  <= sl_bits_reg + 4'h1;
            end else if (scl_fall && sl_bits_reg == BYTE_BITS) begin
              sl_bits_reg <= 4'h0;
              if (sl_state_reg == SL_ADDR) begin
                // R22: address and direction bit
                if (sl_shift_reg[7:1] == own_addr) begin
                  // R5: acknowledge own address
                  sl_sda_low_reg <= 1'b1;
                  sl_rw_reg      <= sl_shift_reg[0];
                  sl_first_reg   <= ~sl_shift_reg[0];
                  sl_state_reg   <= SL_ACK;
                end else begin
                  // R6: stay released
                  sl_state_reg <= SL_IDLE;
                end
              end else begin
                // R7: acknowledge write byte
                sl_sda_low_reg <= 1'b1;
                sl_state_reg   <= SL_ACK;
                sl_first_reg   <= 1'b0;
                if (sl_first_reg) begin
                  sl_ptr_reg <= sl_shift_reg;
                end else begin
                  sl_wr_reg      <= 1'b1;
                  sl_wr_addr_reg <= sl_ptr_reg;
                  sl_wr_data_reg <= sl_shift_reg;
                  sl_ptr_reg     <= sl_ptr_reg + 8'h01;
                end
              end
            end
          end
          SL_ACK: begin
            if (scl_rise) begin
              sl_nack_reg <= sda_s;
            end else if (scl_fall) begin
              // R8: master nack ends the read
              if (sl_rw_reg && !(sl_bits_reg == BYTE_BITS && sl_nack_reg)) begin
                sl_tx_reg      <= sl_rd_byte;
                sl_sda_low_reg <= ~sl_rd_byte[7];
                sl_ptr_reg     <= sl_ptr_reg + 8'h01;
                sl_bits_reg    <= 4'h1;
                sl_state_reg   <= SL_READ;
              end else if (sl_rw_reg) begin
                sl_sda_low_reg <= 1'b0;
                sl_state_reg   <= SL_IDLE;
              end else begin
                sl_sda_low_reg <= 1'b0;
                sl_state_reg   <= SL_WRITE;
              end
            end
          end
          SL_READ: begin
            if (scl_fall) begin
              if (sl_bits_reg == BYTE_BITS) begin
                sl_sda_low_reg <= 1'b0;
                sl_state_reg   <= SL_ACK;
              end else begin
                sl_tx_reg      <= {sl_tx_reg[6:0], 1'b0};
                sl_sda_low_reg <= ~sl_tx_reg[6];
                sl_bits_reg    <= sl_bits_reg + 4'h1;
              end
            end
          end
          default: sl_state_reg <= SL_IDLE;
        endcase
      end
    end
  end

  // R10: low or released only
  assign sda_out = 1'b0;
  assign sda_oe  = sl_sda_low_reg;

  // ======================================================================
  // Proxy master on the back channel
  assign pm_ack_slot = (pm_bit_reg == PM_ACK1) || (pm_bit_reg == PM_ACK2);

  always_ff @(posedge clk_sys) begin
    if (!resetn) begin
      pm_state_reg  <= PM_IDLE;
      pm_cnt_reg    <= 8'h00;
      pm_bit_reg    <= 5'h00;
      pm_shift_reg  <= 18'h3FFFF;
      pm_frame_reg  <= 18'h3FFFF;
      pm_scl_oe_reg <= 1'b0;
      pm_sda_oe_reg <= 1'b0;
      pm_done_reg   <= 1'b0;
      pm_nack_reg   <= 1'b0;
      pm_lost_reg   <= 1'b0;
    end else begin
      pm_done_reg <= 1'b0;
      pm_lost_reg <= 1'b0;
      case (pm_state_reg)
        PM_IDLE: begin
          pm_scl_oe_reg <= 1'b0;
          pm_sda_oe_reg <= 1'b0;
          pm_cnt_reg    <= 8'h00;
          if (pm_req) begin
            pm_frame_reg <= {pm_addr, 1'b0, 1'b1, pm_data, 1'b1};
            pm_nack_reg  <= 1'b0;
            pm_state_reg <= PM_WAIT;
          end
        end
        PM_WAIT: begin
          // R13: wait for idle bus, then restart
          if (!(bscl_sync_reg[1] && bsda_sync_reg[1])) begin
            pm_cnt_reg <= 8'h00;
          end else if (pm_cnt_reg == PM_BUF_CNT) begin
            pm_cnt_reg    <= 8'h00;
            pm_shift_reg  <= pm_frame_reg;
            pm_bit_reg    <= 5'h00;
            pm_sda_oe_reg <= 1'b1;
            pm_state_reg  <= PM_START;
          end else begin
            pm_cnt_reg <= pm_cnt_reg + 8'h01;
          end
        end
        PM_START: begin
          if (pm_cnt_reg == PM_HALF_CNT) begin
            pm_cnt_reg    <= 8'h00;
            pm_scl_oe_reg <= 1'b1;
            pm_state_reg  <= PM_LOW;
          end else begin
            pm_cnt_reg <= pm_cnt_reg + 8'h01;
          end
        end
        PM_LOW: begin
          pm_sda_oe_reg <= ~pm_shift_reg[17];
          if (pm_cnt_reg == PM_HALF_CNT) begin
            pm_cnt_reg    <= 8'h00;
            pm_scl_oe_reg <= 1'b0;
            pm_state_reg  <= PM_HIGH;
          end else begin
            pm_cnt_reg <= pm_cnt_reg + 8'h01;
          end
        end
        PM_HIGH: begin
          if (!bscl_sync_reg[1]) begin
            // R11: stretched clock clears count
            pm_cnt_reg <= 8'h00;
          end else if (pm_shift_reg[17] && !bsda_sync_reg[1] && !pm_ack_slot) begin
            // R12: lost, release at once
            pm_sda_oe_reg <= 1'b0;
            pm_lost_reg   <= 1'b1;
            pm_cnt_reg    <= 8'h00;
            pm_state_reg  <= PM_WAIT;
          end else if (pm_cnt_reg == PM_HALF_CNT) begin
            pm_cnt_reg    <= 8'h00;
            pm_scl_oe_reg <= 1'b1;
            if (pm_ack_slot && bsda_sync_reg[1]) begin
              pm_nack_reg  <= 1'b1;
              pm_state_reg <= PM_STOPL;
            end else if (pm_bit_reg == PM_LAST) begin
              pm_state_reg <= PM_STOPL;
            end else begin
              pm_bit_reg   <= pm_bit_reg + 5'h01;
              pm_shift_reg <= {pm_shift_reg[16:0], 1'b1};
              pm_state_reg <= PM_LOW;
            end
          end else begin
            pm_cnt_reg <= pm_cnt_reg + 8'h01;
          end
        end
        PM_STOPL: begin
          pm_sda_oe_reg <= 1'b1;
          if (pm_cnt_reg == PM_HALF_CNT) begin
            pm_cnt_reg    <= 8'h00;
            pm_scl_oe_reg <= 1'b0;
            pm_state_reg  <= PM_STOPH;
          end else begin
            pm_cnt_reg <= pm_cnt_reg + 8'h01;
          end
        end
        PM_STOPH: begin
          if (!bscl_sync_reg[1]) begin
            pm_cnt_reg <= 8'h00;
          end else if (pm_cnt_reg == PM_HALF_CNT) begin
            // R9: close with stop
            pm_sda_oe_reg <= 1'b0;
            pm_done_reg   <= 1'b1;
            pm_state_reg  <= PM_IDLE;
          end else begin
            pm_cnt_reg <= pm_cnt_reg + 8'h01;
          end
        end
        default: pm_state_reg <= PM_IDLE;
      endcase
    end
  end

  assign back_channel_link_scl_out = 1'b0;
  assign back_channel_link_sda_out = 1'b0;
  assign back_channel_link_scl_oe  = pm_scl_oe_reg;
  assign back_channel_link_sda_oe  = pm_sda_oe_reg;
  assign pm_busy     = (pm_state_reg != PM_IDLE);
  assign pm_done     = pm_done_reg;
  assign pm_nack     = pm_nack_reg;
  assign pm_arb_lost = pm_lost_reg;

endmodule
`default_nettype wire

// [tb/scbsa_core_sva.sv]
// Port checker for the serial slave and proxy master
`timescale 1ns/1ns
`default_nettype none
module scbsa_core_sva
  import scbsa_pkg::*;
(
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic rm_req,
  input wire logic rm_ack,
  input wire logic pm_busy,
  input wire logic pm_done,
  input wire logic pm_arb_lost,
  input wire logic back_channel_link_scl_in,
  input wire logic back_channel_link_scl_out,
  input wire logic back_channel_link_scl_oe,
  input wire logic back_channel_link_sda_in,
  input wire logic back_channel_link_sda_out,
  input wire logic back_channel_link_sda_oe
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // ========
  // Assertions
  property p_line_low;
    !sda_out && !back_channel_link_scl_out && !back_channel_link_sda_out;
  endproperty
  a_line_low: assert property (p_line_low) else $error("line driven high");
  property p_sda_scl_low;
    $changed(sda_oe) |-> !scl_in;
  endproperty
  a_sda_scl_low: assert property (p_sda_scl_low) else $error("sda moved, scl high");
  property p_rm_answer;
    rm_req && !rm_ack |-> ##[1:4] rm_ack;
  endproperty
  a_rm_answer: assert property (p_rm_answer) else $error("no register answer");
  property p_stretch;
    !back_channel_link_scl_oe && !back_channel_link_scl_in |=> !back_channel_link_scl_oe;
  endproperty
  a_stretch: assert property (p_stretch) else $error("scl pulled while held");
  property p_arb_release;
    pm_arb_lost |-> !back_channel_link_sda_oe && !back_channel_link_sda_in;
  endproperty
  a_arb_release: assert property (p_arb_release) else $error("arbitration loss wrong");
  property p_arb_retry;
    pm_arb_lost |=> (pm_busy && !back_channel_link_sda_oe) [*8];
  endproperty
  a_arb_retry: assert property (p_arb_retry) else $error("retry not waiting");
  property p_idle_wait;
    $rose(pm_busy) |-> !back_channel_link_sda_oe [*8];
  endproperty
  a_idle_wait: assert property (p_idle_wait) else $error("start without idle");
  property p_done_stop;
    pm_done |-> !back_channel_link_sda_oe && !back_channel_link_scl_oe;
  endproperty
  a_done_stop: assert property (p_done_stop) else $error("done before stop");
  c_arb: cover property (pm_arb_lost);
  c_rm: cover property (rm_req && rm_ack);
  c_ack: cover property ($rose(sda_oe));
endmodule
bind scbsa_core scbsa_core_sva u_sva (.*);
`default_nettype wire

// [tb/scbsa_host_model.sv]
// Host controller model, sole master of the serial bus
`timescale 1ns/1ns
`default_nettype none
module scbsa_host_model (
  input  wire logic clk_sys,
  input  wire logic sda_line,
  output var logic  scl_oe,
  output var logic  sda_oe
);
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  task automatic i2c_start();
    tick(4);
    sda_oe <= 1'b0;
    tick(4);
    scl_oe <= 1'b0;
    tick(8);
    sda_oe <= 1'b1;
    tick(8);
    scl_oe <= 1'b1;
  endtask
  task automatic i2c_stop();
    tick(4);
    sda_oe <= 1'b1;
    tick(4);
    scl_oe <= 1'b0;
    tick(8);
    sda_oe <= 1'b0;
    tick(8);
  endtask
  task automatic bit_slot(input logic b, output logic s);
    tick(4);
    sda_oe <= ~b;
    tick(4);
    scl_oe <= 1'b0;
    tick(4);
    s = sda_line;
    tick(4);
    scl_oe <= 1'b1;
  endtask
  task automatic put_byte(input logic [7:0] d, output logic ackd);
    logic s;
    for (int i = 7; i >= 0; i--) bit_slot(d[i], s);
    bit_slot(1'b1, s);
    ackd = ~s;
  endtask
  task automatic get_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_slot(1'b1, d[i]);
    bit_slot(last, s);
  endtask
endmodule
`default_nettype wire

// [tb/scbsa_core_tb.sv]
// Testbench for the serial slave, register port and proxy master
`timescale 1ns/1ns
`default_nettype none
module scbsa_core_tb
  import scbsa_pkg::*;
;
  logic       clk_sys = 1'b0;
  logic       resetn = 1'b0;
  logic [2:0] strap = 3'h0;
  logic       rm_req = 1'b0;
  logic       rm_we = 1'b0;
  logic [7:0] rm_addr = 8'h00;
  logic [7:0] rm_wdata = 8'h00;
  logic       pm_req = 1'b0;
  logic       bc_scl_hold = 1'b0;
  logic       bc_sda_hold = 1'b0;
  logic       rm_ack, pm_busy, pm_done, pm_nack, pm_arb_lost, sda_out, sda_oe, a;
  logic       h_scl_oe, h_sda_oe, bc_scl_oe, bc_sda_oe;
  logic [7:0] rm_rdata, d0, d1;
  logic [3:0] acks;
  int         mismatches = 0;
  int         tests_run = 0;
  int         arb_count = 0;
  wire        scl = ~h_scl_oe;
  wire        sda = ~(h_sda_oe | sda_oe);
  wire        bc_scl = ~(bc_scl_oe | bc_scl_hold);
  wire        bc_sda = ~(bc_sda_oe | bc_sda_hold);
  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (pm_arb_lost === 1'b1) arb_count <= arb_count + 1;
  scbsa_core dut (.clk_sys(clk_sys), .resetn(resetn), .address_strap_pin(strap),
    .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .rm_req(rm_req),
    .rm_we(rm_we), .rm_addr(rm_addr), .rm_wdata(rm_wdata), .rm_ack(rm_ack),
    .rm_rdata(rm_rdata), .pm_req(pm_req), .pm_addr(7'h50), .pm_data(8'hC5),
    .pm_busy(pm_busy), .pm_done(pm_done), .pm_nack(pm_nack), .pm_arb_lost(pm_arb_lost),
    .back_channel_link_scl_in(bc_scl), .back_channel_link_scl_out(),
    .back_channel_link_scl_oe(bc_scl_oe), .back_channel_link_sda_in(bc_sda),
    .back_channel_link_sda_out(), .back_channel_link_sda_oe(bc_sda_oe));
  scbsa_host_model host (.clk_sys(clk_sys), .sda_line(sda), .scl_oe(h_scl_oe),
    .sda_oe(h_sda_oe));
  // ========
  // Tasks
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic bound(input int n, input int lim);
    if (n >= lim) begin
      mismatches++;
      $display("wrong value wait expected done seen timeout");
      summarize();
    end
  endtask
  task automatic do_reset(input logic [2:0] lvl);
    @(posedge clk_sys);
    strap <= lvl;
    resetn <= 1'b0;
    repeat (12) @(posedge clk_sys);
    resetn <= 1'b1;
    repeat (6) @(posedge clk_sys);
  endtask
  task automatic rm_rw(input logic we, input logic [7:0] ad, input logic [7:0] wd,
                       output logic [7:0] rd);
    int n;
    @(posedge clk_sys);
    rm_req <= 1'b1;
    rm_we <= we;
    rm_addr <= ad;
    rm_wdata <= wd;
    for (n = 0; n < 20 && rm_ack !== 1'b1; n++) @(negedge clk_sys);
    bound(n, 20);
    rd = rm_rdata;
    @(posedge clk_sys);
    rm_req <= 1'b0;
  endtask
  task automatic probe(input logic [6:0] ad, output logic ack);
    host.i2c_start();
    host.put_byte({ad, 1'b0}, ack);
    host.i2c_stop();
  endtask
  task automatic h_write(input logic [6:0] ad, input logic [7:0] ofs, input logic [7:0] x,
                         input logic [7:0] y, output logic [3:0] k);
    host.i2c_start();
    host.put_byte({ad, 1'b0}, k[3]);
    host.put_byte(ofs, k[2]);
    host.put_byte(x, k[1]);
    host.put_byte(y, k[0]);
    host.i2c_stop();
  endtask
  task automatic h_read(input logic [6:0] ad, input logic [7:0] ofs, output logic [7:0] x,
                        output logic [7:0] y);
    logic k;
    host.i2c_start();
    host.put_byte({ad, 1'b0}, k);
    host.put_byte(ofs, k);
    host.i2c_start();
    host.put_byte({ad, 1'b1}, k);
    host.get_byte(1'b0, x);
    host.get_byte(1'b1, y);
    host.i2c_stop();
  endtask
  task automatic pm_run(input logic fight);
    int n;
    @(posedge clk_sys);
    pm_req <= 1'b1;
    @(posedge clk_sys);
    pm_req <= 1'b0;
    for (n = 0; n < 400 && bc_scl_oe !== 1'b1; n++) @(negedge clk_sys);
    bound(n, 400);
    for (n = 0; n < 400 && bc_scl_oe !== 1'b0; n++) @(negedge clk_sys);
    bound(n, 400);
    @(posedge clk_sys);
    bc_sda_hold <= fight;
    bc_scl_hold <= ~fight;
    repeat (100) @(posedge clk_sys);
    bc_sda_hold <= 1'b0;
    bc_scl_hold <= 1'b0;
    for (n = 0; n < 9000 && pm_done !== 1'b1; n++) @(negedge clk_sys);
    bound(n, 9000);
  endtask
  // ========
  // Sequence
  initial begin
    for (int lvl = 0; lvl < 8; lvl++) begin
      do_reset(lvl[2:0]);
      probe(STRAP_ADDR[lvl], a);
      check("strap ack", {7'h00, a}, 8'h01);
      probe(STRAP_ADDR[lvl ^ 1], a);
      check("other nack", {7'h00, a}, 8'h00);
      rm_rw(1'b0, 8'h00, 8'h00, d0);
      check("offset 0", d0, {STRAP_ADDR[lvl], 1'b0});
    end
    $display("test strap done");
    do_reset(3'h0);
    h_write(7'h2C, 8'h18, 8'h55, 8'hA3, acks);
    check("write acks", {4'h0, acks}, 8'h0F);
    rm_rw(1'b0, 8'h18, 8'h00, d0);
    check("mailbox 18", d0, 8'h55);
    rm_rw(1'b0, 8'h19, 8'h00, d0);
    check("mailbox 19", d0, 8'hA3);
    h_read(7'h2C, 8'h18, d0, d1);
    check("read 18", d0, 8'h55);
    check("read 19", d1, 8'hA3);
    $display("test host access done");
    rm_rw(1'b1, 8'h40, 8'h77, d0);
    rm_rw(1'b0, 8'h40, 8'h00, d0);
    check("unmapped", d0, 8'h00);
    rm_rw(1'b1, 8'h00, 8'h45, d0);
    probe(7'h22, a);
    check("stored ack", {7'h00, a}, 8'h01);
    probe(7'h2C, a);
    check("strap nack", {7'h00, a}, 8'h00);
    rm_rw(1'b1, 8'h00, 8'h58, d0);
    probe(7'h2C, a);
    check("strap back", {7'h00, a}, 8'h01);
    $display("test register port done");
    fork
      h_write(7'h2C, 8'h18, 8'h11, 8'h22, acks);
      for (int k = 0; k < 250; k++) rm_rw(1'b1, 8'h19, k[7:0], d1);
    join
    rm_rw(1'b1, 8'h19, 8'hEE, d0);
    rm_rw(1'b0, 8'h18, 8'h00, d0);
    check("shared 18", d0, 8'h11);
    rm_rw(1'b0, 8'h19, 8'h00, d0);
    check("shared 19", d0, 8'hEE);
    check("shared acks", {4'h0, acks}, 8'h0F);
    $display("test shared access done");
    pm_run(1'b0);
    check("stretch nack", {7'h00, pm_nack}, 8'h01);
    pm_run(1'b1);
    check("arb lost", arb_count[7:0], 8'h01);
    check("retry nack", {7'h00, pm_nack}, 8'h01);
    $display("test proxy done");
    summarize();
  end
endmodule
`default_nettype wire
